// *** rtl/rst_cause_cfg.svh ***
// Constants for the reset cause and source select block
//
// Behaviour
// - Writing one to the soft reset bit forces a system reset at once.
// - Soft reset flag reads one afterwards; the reset pin is not driven.
// - Writing zero to the soft reset bit does nothing; flag zero otherwise.
// - Top bit of the cause register reads zero; writes ignored.
// - Flash fault flag reads one only after a flash access fault reset.
// - Comparator bit write selects the comparator; read shows comparator cause.
// - Watchdog flag reads one only after a watchdog timeout reset.
// - Clock-loss bit write enables the detector; read shows clock-loss cause.
// - Enabled detector resets when no clock edge comes within 100 to 600 us.
// - Power-cause bit reads one after power-on and supply monitor resets.
// - Writing the power-cause bit selects or deselects the supply monitor.
// - With the power-cause bit set, all other flags are indeterminate.
// - Pin cause flag reads one only after an external pin reset.
// - Read-modify-write of the three select bits sees enables, not flags; soft bit reads zero.
// - Execution begins at 0x0000 at least 5.0 us after sources release.
// - Any reset other than power-on or supply monitor clears the power-cause flag.
// - Monitor on bit turns the monitor on; when off it cannot reset.
// - No extra power-on delay is added after a supply monitor reset.
`ifndef RST_CAUSE_CFG_SVH
`define RST_CAUSE_CFG_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define RCR_ADDR 8'hEF
`define SMC_ADDR 8'hFF

// ----------------------------------------
// Cause register bit positions
// ----------------------------------------
`define BIT_UNUSED 7
`define BIT_FLASH 6
`define BIT_COMP 5
`define BIT_SOFT 4
`define BIT_WDOG 3
`define BIT_CLKLOSS 2
`define BIT_POWER 1
`define BIT_PIN 0

// ----------------------------------------
// Supply monitor control bit positions
// ----------------------------------------
`define BIT_MON_ON 7
`define BIT_MON_OK 6

// ----------------------------------------
// Reset values and start address
// ----------------------------------------
`define RCR_POR_FLAGS 8'h02
`define BOOT_ADDR 16'h0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 5
`define CLK_LOSS_MIN_US 100
`define CLK_LOSS_MAX_US 600
`define RESET_DELAY_NS 5000
`define POR_EXTRA_US 300

`endif

// *** rtl/rst_cause_pkg.sv ***
// Types for the reset cause and source select block
package rst_cause_pkg;

   // ----------------------------------------
   // Reset sequencer states
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_HOLD = 3'b010,
      ST_DELAY = 3'b100
   } seq_state_e;

   // One bit per reset source, same layout as the cause register
   typedef logic [7:0] cause_t;

endpackage : rst_cause_pkg

// *** rtl/clock_loss_monitor.sv ***
// Missing clock watchdog counting core clock cycles between monitored edges
module clock_loss_monitor #(
   parameter int TIMEOUT_CYC = 20000
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Control
   input wire logic enable,
   input wire logic sys_clk_level,
   // Result
   output logic timeout
);

   localparam int CNT_W = $clog2(TIMEOUT_CYC + 1);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(TIMEOUT_CYC - 1);

   // ----------------------------------------
   // Elaboration check
   // ----------------------------------------
   if (TIMEOUT_CYC < 2) begin : g_bad
      $error("clock_loss_monitor: TIMEOUT_CYC must be at least 2");
   end

   logic prev_level;
   logic [CNT_W-1:0] count;
   logic rise;

   assign rise = sys_clk_level && !prev_level;

   // Edge memory
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         prev_level <= 1'b0;
      end else begin
         prev_level <= sys_clk_level;
      end
   end

   // Cycles since the last rising edge; a rising edge restarts the count
   always_ff @(posedge core_clk) begin
      if (!rst_n || !enable || rise) begin
         count <= '0;
         timeout <= 1'b0;
      end else if (count == LAST) begin
         timeout <= 1'b1;
      end else begin
         count <= count + CNT_W'(1);
      end
   end

endmodule : clock_loss_monitor

// *** rtl/reset_cause_and_source_select.sv ***
// Reset source merging, cause recording and release sequencing
`include "rst_cause_cfg.svh"

module reset_cause_and_source_select
   import rst_cause_pkg::*;
#(
   parameter int CLK_LOSS_CYC =
      (`CLK_LOSS_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int POR_EXTRA_CYC =
      (`POR_EXTRA_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int DELAY_W = 17
) (
   // Clock and power-on reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Special function register port
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic sfr_rmw,
   output logic [7:0] sfr_rdata,
   // Reset sources
   input wire logic pin_rst_n,
   input wire logic comp_out_n,
   input wire logic wdog_timeout,
   input wire logic flash_fault,
   input wire logic supply_ok,
   input wire logic sys_clk_level,
   // External reset pin, open drain
   output logic pin_rst_out,
   output logic pin_rst_oe,
   // System side
   output logic sys_reset_n,
   output logic [15:0] fetch_addr,
   output logic supply_monitor_on
);

   // ----------------------------------------
   // Derived timing and elaboration checks
   // ----------------------------------------
   localparam int RESET_DELAY_CYC =
      (`RESET_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int CLK_LOSS_MAX_CYC = `CLK_LOSS_MAX_US * 1000 / `CLK_PERIOD_NS;
   localparam logic [DELAY_W-1:0] RELEASE_LOAD = DELAY_W'(RESET_DELAY_CYC);
   localparam logic [DELAY_W-1:0] POR_LOAD =
      DELAY_W'(POR_EXTRA_CYC + RESET_DELAY_CYC);

   if (POR_EXTRA_CYC + RESET_DELAY_CYC >= 2 ** DELAY_W) begin : g_bad_width
      $error("reset_cause_and_source_select: DELAY_W too narrow");
   end
   if (CLK_LOSS_CYC < 2 || CLK_LOSS_CYC > CLK_LOSS_MAX_CYC) begin : g_bad_loss
      $error("reset_cause_and_source_select: CLK_LOSS_CYC out of range");
   end
   if (RESET_DELAY_CYC < 1) begin : g_bad_delay
      $error("reset_cause_and_source_select: release delay below one cycle");
   end

   // ----------------------------------------
   // State
   // ----------------------------------------
   seq_state_e state;
   logic [DELAY_W-1:0] delay_cnt;
   cause_t cause_acc;
   cause_t flags;
   logic comp_sel;
   logic clk_loss_en;
   logic supply_sel;
   logic clk_loss_timeout;
   cause_t src_now;
   logic any_src;
   logic rcr_wr;
   logic smc_wr;
   logic soft_force;
   logic [7:0] rcr_normal;
   logic [7:0] rcr_rmw;
   logic [7:0] smc_read;

   // ----------------------------------------
   // Register decode; writes only land while the core runs
   // ----------------------------------------
   assign rcr_wr = sfr_wr && sys_reset_n && (sfr_addr == `RCR_ADDR);
   assign smc_wr = sfr_wr && sys_reset_n && (sfr_addr == `SMC_ADDR);
   // Only a one forces; a zero written to the bit has no effect
   assign soft_force = rcr_wr && sfr_wdata[`BIT_SOFT];

   // ----------------------------------------
   // Missing clock detector
   // ----------------------------------------
   clock_loss_monitor #(
      .TIMEOUT_CYC(CLK_LOSS_CYC)
   ) u_clock_loss (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .enable(clk_loss_en),
      .sys_clk_level(sys_clk_level),
      .timeout(clk_loss_timeout)
   );

   // ----------------------------------------
   // Live reset requests, one per cause bit
   // ----------------------------------------
   assign src_now[`BIT_UNUSED] = 1'b0;
   assign src_now[`BIT_FLASH] = flash_fault;
   assign src_now[`BIT_COMP] = comp_sel && !comp_out_n;
   assign src_now[`BIT_SOFT] = soft_force;
   assign src_now[`BIT_WDOG] = wdog_timeout;
   assign src_now[`BIT_CLKLOSS] = clk_loss_en && clk_loss_timeout;
   // A monitor that is off raises nothing even when selected
   assign src_now[`BIT_POWER] = supply_sel && supply_monitor_on && !supply_ok;
   // Any low sample counts; holding it long enough is the outside's duty
   assign src_now[`BIT_PIN] = !pin_rst_n;
   assign any_src = |src_now;

   // ----------------------------------------
   // Source selects and monitor enable; cleared only by power-on
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         comp_sel <= 1'b0;
         clk_loss_en <= 1'b0;
         supply_sel <= 1'b0;
      end else if (rcr_wr) begin
         comp_sel <= sfr_wdata[`BIT_COMP];
         clk_loss_en <= sfr_wdata[`BIT_CLKLOSS];
         supply_sel <= sfr_wdata[`BIT_POWER];
      end
   end

   // Supply monitor on bit survives every reset except power-on
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         supply_monitor_on <= 1'b0;
      end else if (smc_wr) begin
         supply_monitor_on <= sfr_wdata[`BIT_MON_ON];
      end
   end

   // ----------------------------------------
   // Reset sequencer
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state <= ST_DELAY;
         delay_cnt <= POR_LOAD;
         cause_acc <= '0;
      end else begin
         unique case (state)
            ST_RUN: begin
               if (any_src) begin
                  state <= ST_HOLD;
                  cause_acc <= src_now;
               end
            end
            ST_HOLD: begin
               cause_acc <= cause_acc | src_now;
               if (!any_src) begin
                  state <= ST_DELAY;
                  // Supply monitor release gets the plain delay only
                  delay_cnt <= RELEASE_LOAD;
               end
            end
            ST_DELAY: begin
               if (any_src) begin
                  state <= ST_HOLD;
                  cause_acc <= src_now;
               end else if (delay_cnt == DELAY_W'(1)) begin
                  state <= ST_RUN;
               end else begin
                  delay_cnt <= delay_cnt - DELAY_W'(1);
               end
            end
         endcase
      end
   end

   // System reset output: low the edge after any request, high after the delay
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sys_reset_n <= 1'b0;
      end else if (any_src) begin
         sys_reset_n <= 1'b0;
      end else if (state == ST_DELAY && delay_cnt == DELAY_W'(1)) begin
         sys_reset_n <= 1'b1;
      end
   end

   // Start address presented to the core at release
   always_ff @(posedge core_clk) begin
      fetch_addr <= `BOOT_ADDR;
   end

   // ----------------------------------------
   // Cause flags, latched when the sources let go
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         // Power-on: power-cause set, the rest are don't-care and shown as zero
         flags <= `RCR_POR_FLAGS;
      end else if (state == ST_HOLD && !any_src) begin
         // Flags mirror the captured sources; other causes clear power-cause
         flags <= cause_acc;
         flags[`BIT_UNUSED] <= 1'b0;
      end
   end

   // ----------------------------------------
   // Reset pin: driven only by power-on and the supply monitor
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pin_rst_oe <= 1'b1;
      end else begin
         pin_rst_oe <= src_now[`BIT_POWER];
      end
   end

   // Open drain: only ever pulls low
   always_ff @(posedge core_clk) begin
      pin_rst_out <= 1'b0;
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always_comb begin
      rcr_normal = flags;
      rcr_normal[`BIT_UNUSED] = 1'b0;
      rcr_rmw = rcr_normal;
      rcr_rmw[`BIT_COMP] = comp_sel;
      rcr_rmw[`BIT_SOFT] = 1'b0;
      rcr_rmw[`BIT_CLKLOSS] = clk_loss_en;
      rcr_rmw[`BIT_POWER] = supply_sel;
      smc_read = 8'h00;
      smc_read[`BIT_MON_ON] = supply_monitor_on;
      smc_read[`BIT_MON_OK] = supply_ok;
   end

   // Registered read port; unmapped addresses return zero
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         if (sfr_addr == `RCR_ADDR) begin
            sfr_rdata <= sfr_rmw ? rcr_rmw : rcr_normal;
         end else if (sfr_addr == `SMC_ADDR) begin
            sfr_rdata <= smc_read;
         end else begin
            sfr_rdata <= 8'h00;
         end
      end
   end

endmodule : reset_cause_and_source_select

// *** tb/rst_cause_asserts.sv ***
// Port assertions for the reset cause block
module rst_cause_asserts (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic sfr_rmw,
   input wire logic [7:0] sfr_rdata,
   // Sources and outputs
   input wire logic pin_rst_n,
   input wire logic wdog_timeout,
   input wire logic flash_fault,
   input wire logic pin_rst_oe,
   input wire logic pin_rst_out,
   input wire logic sys_reset_n,
   input wire logic [15:0] fetch_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   int lo_cnt = 0;
   // Length of the current system reset
   always_ff @(posedge core_clk) begin
      lo_cnt <= sys_reset_n ? 0 : lo_cnt + 1;
   end
   sequence s_soft_wr;
      sfr_wr && sfr_addr == 8'hEF && sfr_wdata[4] && sys_reset_n;
   endsequence
   sequence s_release;
      $rose(sys_reset_n);
   endsequence
   property p_soft; s_soft_wr |=> !sys_reset_n; endproperty
   property p_soft_pin; s_soft_wr ##0 !pin_rst_oe |=> !pin_rst_oe [*2]; endproperty
   property p_delay; s_release |-> lo_cnt >= 1000; endproperty
   property p_fetch; s_release |-> fetch_addr == 16'h0000; endproperty
   property p_bit7; sfr_rd |=> !sfr_rdata[7]; endproperty
   property p_rmw; sfr_rd && sfr_rmw && sfr_addr == 8'hEF |=> !sfr_rdata[4]; endproperty
   property p_pin; !pin_rst_n && sys_reset_n |-> ##[1:3] !sys_reset_n; endproperty
   property p_hold; !pin_rst_n && !sys_reset_n |=> !sys_reset_n; endproperty
   property p_src; (wdog_timeout || flash_fault) && sys_reset_n |-> ##[1:3] !sys_reset_n;
   endproperty
   a_soft: assert property (p_soft) else $error("soft reset not forced");
   a_soft_pin: assert property (p_soft_pin) else $error("pin driven on soft reset");
   a_delay: assert property (p_delay) else $error("reset released too early");
   a_fetch: assert property (p_fetch) else $error("start address not zero");
   a_bit7: assert property (p_bit7) else $error("top bit read as one");
   a_rmw: assert property (p_rmw) else $error("soft bit seen in rmw read");
   a_pin: assert property (p_pin) else $error("pin request ignored");
   a_hold: assert property (p_hold) else $error("reset dropped during pin request");
   a_src: assert property (p_src) else $error("watchdog or flash request ignored");
   // Open drain pin only ever pulls low, and only during a system reset
   property p_pin_drv; pin_rst_oe |-> !pin_rst_out; endproperty
   property p_oe; pin_rst_oe |-> !sys_reset_n; endproperty
   a_pin_drv: assert property (p_pin_drv) else $error("reset pin driven high");
   a_oe: assert property (p_oe) else $error("reset pin pulled outside a reset");
endmodule : rst_cause_asserts

bind reset_cause_and_source_select rst_cause_asserts chk_u (.core_clk(core_clk),
   .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
   .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw), .sfr_rdata(sfr_rdata), .pin_rst_n(pin_rst_n),
   .wdog_timeout(wdog_timeout), .flash_fault(flash_fault), .pin_rst_oe(pin_rst_oe),
   .pin_rst_out(pin_rst_out),
   .sys_reset_n(sys_reset_n), .fetch_addr(fetch_addr));

// *** tb/rst_src_model.sv ***
// Reset sources around the block: pin, comparator, watchdog, flash, supply, clock
module rst_src_model (
   // Clock
   input wire logic core_clk,
   // Command from the bench
   input wire logic go,
   input wire logic [2:0] kind,
   // Source levels
   output logic pin_rst_n,
   output logic comp_out_n,
   output logic wdog_timeout,
   output logic flash_fault,
   output logic supply_ok,
   output logic sys_clk_level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_stop = 1'b0;
   logic clk_lvl = 1'b0;
   int len;
   // One process owns the monitored clock level
   assign sys_clk_level = clk_lvl;
   // Free running system clock, halted on command
   always @(posedge core_clk) begin
      if (!clk_stop) begin
         clk_lvl <= ~clk_lvl;
      end
   end
   // One source event per command, then back to idle
   initial begin
      {pin_rst_n, comp_out_n, supply_ok, wdog_timeout, flash_fault} = 5'b11100;
      forever begin
         @(posedge core_clk);
         if (go) begin
            len = (kind == 3'd1) ? 3000 : (kind == 3'd6) ? 40 : 20;
            pin_rst_n <= (kind != 3'd1);
            comp_out_n <= (kind != 3'd2);
            wdog_timeout <= (kind == 3'd3);
            flash_fault <= (kind == 3'd4);
            supply_ok <= (kind != 3'd5);
            clk_stop <= (kind == 3'd6);
            repeat (len) @(posedge core_clk);
            {pin_rst_n, comp_out_n, supply_ok, wdog_timeout, flash_fault} <= 5'b11100;
            clk_stop <= 1'b0;
         end
      end
   end
endmodule : rst_src_model

// *** tb/tb.sv ***
// Self-checking bench for the reset cause and source select block
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] sfr_addr = 8'h00;
   logic [7:0] sfr_wdata = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic sfr_rmw = 1'b0;
   logic go = 1'b0;
   logic rd_d = 1'b0;
   logic [2:0] kind = 3'd0;
   logic [7:0] sfr_rdata, lfsr;
   logic pin_rst_n, comp_out_n, wdog_timeout, flash_fault, supply_ok, sys_clk_level;
   logic pin_rst_out, pin_rst_oe, sys_reset_n, supply_monitor_on;
   logic [15:0] fetch_addr;
   logic [7:0] exp_q[$];
   int n_fail = 0;
   int checked = 0;

   always #2.5 core_clk = ~core_clk;

   reset_cause_and_source_select #(.CLK_LOSS_CYC(16), .POR_EXTRA_CYC(10)) dut_u (
      .core_clk(core_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw), .sfr_rdata(sfr_rdata),
      .pin_rst_n(pin_rst_n), .comp_out_n(comp_out_n), .wdog_timeout(wdog_timeout),
      .flash_fault(flash_fault), .supply_ok(supply_ok), .sys_clk_level(sys_clk_level),
      .pin_rst_out(pin_rst_out), .pin_rst_oe(pin_rst_oe), .sys_reset_n(sys_reset_n),
      .fetch_addr(fetch_addr), .supply_monitor_on(supply_monitor_on));

   rst_src_model src_u (.core_clk(core_clk), .go(go), .kind(kind), .pin_rst_n(pin_rst_n),
      .comp_out_n(comp_out_n), .wdog_timeout(wdog_timeout), .flash_fault(flash_fault),
      .supply_ok(supply_ok), .sys_clk_level(sys_clk_level));

   function automatic logic [7:0] lfsr_next(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : lfsr_next

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge core_clk);
      sfr_wr <= 1'b0;
      @(posedge core_clk);
   endtask : wr

   // Note the expected byte, then issue the read
   task automatic rd(input logic [7:0] a, input logic rmw, input logic [7:0] exp);
      exp_q.push_back(exp);
      sfr_addr <= a;
      sfr_rmw <= rmw;
      sfr_rd <= 1'b1;
      @(posedge core_clk);
      sfr_rd <= 1'b0;
      sfr_rmw <= 1'b0;
      @(posedge core_clk);
   endtask : rd

   task automatic wait_rst(input logic lvl, input int bound);
      int i;
      for (i = 0; i < bound && sys_reset_n !== lvl; i++) begin
         @(posedge core_clk);
      end
      if (sys_reset_n !== lvl) begin
         n_fail++;
         $display("Error sys_reset_n expected %b seen %b", lvl, sys_reset_n);
         report_and_stop();
      end
   endtask : wait_rst

   task automatic src(input logic [2:0] k);
      kind <= k;
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      @(posedge core_clk);
   endtask : src

   // Ride through one system reset, then read the cause
   task automatic settle(input logic [7:0] flags);
      wait_rst(1'b0, 100);
      wait_rst(1'b1, 5000);
      rd(8'hEF, 1'b0, flags);
   endtask : settle

   task automatic quiet(input int n);
      logic ok;
      ok = 1'b1;
      repeat (n) begin
         @(posedge core_clk);
         ok &= (sys_reset_n === 1'b1);
      end
      check({7'h00, ok}, 8'h01, "sys_reset_n held");
   endtask : quiet

   // Read data monitor: compare each answer with the oldest note
   always @(posedge core_clk) begin
      if (rd_d) begin
         check(sfr_rdata, exp_q.pop_front(), "sfr_rdata");
      end
      rd_d <= sfr_rd;
   end

   // Main sequence
   initial begin
      lfsr = 8'h58;
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      wait_rst(1'b1, 2000);
      rd(8'hEF, 1'b0, 8'h02);
      repeat (4) begin
         lfsr = lfsr_next(lfsr);
         rd({lfsr[7:5], 1'b1, lfsr[3:1], 1'b0}, 1'b0, 8'h00);
      end
      wr(8'hEF, 8'hC9);
      quiet(20);
      rd(8'hEF, 1'b1, 8'h00);
      rd(8'hEF, 1'b0, 8'h02);
      src(3'd1);
      settle(8'h01);
      wr(8'hEF, 8'h24);
      src(3'd3);
      settle(8'h08);
      rd(8'hEF, 1'b1, 8'h2C);
      src(3'd4);
      settle(8'h40);
      src(3'd2);
      settle(8'h20);
      src(3'd6);
      settle(8'h04);
      wr(8'hEF, 8'h34);
      settle(8'h10);
      rd(8'hEF, 1'b1, 8'h24);
      wr(8'hEF, 8'h02);
      src(3'd6);
      quiet(60);
      src(3'd5);
      quiet(40);
      lfsr = lfsr_next(lfsr);
      wr(8'hFF, {1'b1, lfsr[6:0]});
      check({7'h00, supply_monitor_on}, 8'h01, "supply_monitor_on");
      repeat (20000) @(posedge core_clk);
      wr(8'hEF, 8'h02);
      src(3'd5);
      @(posedge core_clk);
      check({7'h00, pin_rst_oe}, 8'h01, "pin_rst_oe");
      settle(8'h02);
      rd(8'hEF, 1'b1, 8'h02);
      repeat (3) @(posedge core_clk);
      report_and_stop();
   end
endmodule : tb
